/* File: pcc_pkg.sv */
// Package for the modulator clock, alignment and concatenation configuration block.
// Assumes a single bus clock; register byte addresses sit on a 32-bit Avalon-MM slave.
package pcc_pkg;
	localparam int NUM_CHAN = 6;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PRE_W = 3;
	localparam int SCALE_W = 8;
	localparam int DIV_W = 7;
	localparam int SCNT_W = 9;
	localparam logic [ADDR_W-1:0] OFF_CLK_SEL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_PRESCALE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_ALIGN = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_SCALE_A = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_SCALE_B = 8'h14;
	localparam int PRE_A_LSB = 0;
	localparam int PRE_B_LSB = 4;
	localparam int JOIN_LO_BIT = 4;
	localparam int JOIN_MID_BIT = 5;
	localparam int JOIN_HI_BIT = 6;
	localparam logic [7:0] CLK_SEL_MASK = 8'h3f;
	localparam logic [7:0] PRESCALE_MASK = 8'h77;
	localparam logic [7:0] ALIGN_MASK = 8'h3f;
	localparam logic [7:0] CONTROL_MASK = 8'h70;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [5:0] CHAN_USES_B = 6'h0c;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;
	localparam logic [SCNT_W-1:0] SCALE_ZERO_FULL = 9'h100;
	localparam logic [SCNT_W-1:0] SCNT_ONE = 9'h001;
	localparam logic [DIV_W-1:0] DIV_ONE = 7'h01;
	localparam logic [DIV_W-1:0] DIV_ALL_ONES = 7'h7f;
endpackage : pcc_pkg

/* File: pcc_clock_align_cfg.sv */
// Clock source selection, prescalers, scalers, alignment and pair joining for six channels.
// Assumes an Avalon-MM master on sys_clk_i; channel counters consume the outputs.
//
// What this block does
// - Channels 0, 1, 4 and 5 take prescaled clock A when their select bit is 0 and scaled A when 1.
// - Channels 2 and 3 take prescaled clock B when their select bit is 0 and scaled B when 1.
// - The six select bits can be read and written at any time and a write is stalled for one wait cycle only.
// - Clock B is the bus clock divided by two to the power of its 3-bit select.
// - Clock A is the bus clock divided by two to the power of its 3-bit select.
// - The prescale register holds independent A and B select fields, writable at any time.
// - Select and prescale changes act at once with no period resynchronisation.
// - A set alignment bit makes its channel center aligned and a clear bit left aligned.
// - Three control bits join channel pairs 0-1, 2-3 and 4-5 into 16-bit channels.
// - In a joined pair the even channel holds the high bytes and the odd one the low bytes.
// - In a joined pair the odd channel's select and alignment govern and its pin carries output.
// - Each scaled clock is its prescaled clock divided by twice the scale, zero meaning 256.
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module pcc_clock_align_cfg (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [pcc_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [pcc_pkg::DATA_W-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [pcc_pkg::DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [pcc_pkg::NUM_CHAN-1:0] chan_clk_en_o,
	output logic [pcc_pkg::NUM_CHAN-1:0] center_align_en_o,
	output logic [pcc_pkg::NUM_CHAN-1:0] chan_out_active_o,
	output logic [2:0] pair_join_o,
	output logic clock_a_en_o,
	output logic clock_b_en_o,
	output logic scaled_a_clk_o,
	output logic scaled_b_clk_o
);
	import pcc_pkg::*;

	typedef struct packed {
		logic [7:0] clk_sel;
		logic [7:0] prescale;
		logic [7:0] align;
		logic [7:0] control;
		logic [SCALE_W-1:0] scale_a_value;
		logic [SCALE_W-1:0] scale_b_value;
		logic [DIV_W-1:0] div_cnt;
		logic [SCNT_W-1:0] scnt_a;
		logic [SCNT_W-1:0] scnt_b;
		logic scaled_a_en;
		logic scaled_b_en;
		logic scaled_a_clk;
		logic scaled_b_clk;
		logic [DIV_W-1:0] div_prev;
		logic ack;
		logic [DATA_W-1:0] rdata;
		logic [NUM_CHAN-1:0] chan_en;
	} pcc_state_t;

	pcc_state_t state_reg;
	pcc_state_t state_next;

	logic [PRE_W-1:0] prescale_a_sel;
	logic [PRE_W-1:0] prescale_b_sel;
	logic [DIV_W-1:0] div_inc;
	logic [DIV_W-1:0] rise_bits;
	logic pre_a_en;
	logic pre_b_en;
	logic wr_lane0;

	function automatic logic [SCNT_W-1:0] reload(input logic [SCALE_W-1:0] v);
		reload = (v == '0) ? SCALE_ZERO_FULL : {1'b0, v};
	endfunction : reload

	// A prescaled enable fires when bit (sel-1) of the shared counter wraps to zero,
	// so every A and B edge lines up with one common count.
	function automatic logic pre_tick(input logic [PRE_W-1:0] sel,
		input logic [DIV_W-1:0] falls);
		if (sel == '0) begin
			pre_tick = 1'b1;
		end else begin
			pre_tick = falls[sel - 3'd1];
		end
	endfunction : pre_tick

	always_comb begin
		prescale_a_sel = state_reg.prescale[PRE_A_LSB +: PRE_W];
		prescale_b_sel = state_reg.prescale[PRE_B_LSB +: PRE_W];
		div_inc = state_reg.div_cnt + DIV_ONE;
		// A bit falling from 1 to 0 marks one full period of its power of two.
		rise_bits = state_reg.div_prev & ~state_reg.div_cnt;
		pre_a_en = pre_tick(prescale_a_sel, rise_bits);
		pre_b_en = pre_tick(prescale_b_sel, rise_bits);
		// A write lands only at the edge where waitrequest is low, as the master expects.
		wr_lane0 = avs_write_i && avs_byteenable_i[0] && state_reg.ack;
		state_next = state_reg;
		state_next.div_cnt = div_inc;
		state_next.div_prev = state_reg.div_cnt;
		state_next.scaled_a_en = 1'b0;
		state_next.scaled_b_en = 1'b0;
		// Scaled clocks toggle each time the scale count expires, which gives the factor of two.
		if (pre_a_en) begin
			if (state_reg.scnt_a == SCNT_ONE) begin
				state_next.scnt_a = reload(state_reg.scale_a_value);
				state_next.scaled_a_clk = ~state_reg.scaled_a_clk;
				// Only the rising toggle clocks a channel, so a channel sees one tick per full period.
				state_next.scaled_a_en = ~state_reg.scaled_a_clk;
			end else begin
				state_next.scnt_a = state_reg.scnt_a - SCNT_ONE;
			end
		end
		if (pre_b_en) begin
			if (state_reg.scnt_b == SCNT_ONE) begin
				state_next.scnt_b = reload(state_reg.scale_b_value);
				state_next.scaled_b_clk = ~state_reg.scaled_b_clk;
				state_next.scaled_b_en = ~state_reg.scaled_b_clk;
			end else begin
				state_next.scnt_b = state_reg.scnt_b - SCNT_ONE;
			end
		end
		state_next.ack = 1'b0;
		state_next.rdata = UNMAPPED_READ;
		if ((avs_read_i || avs_write_i) && !state_reg.ack) begin
			state_next.ack = 1'b1;
			if (avs_address_i == OFF_CLK_SEL) begin
				state_next.rdata = {24'h000000, state_reg.clk_sel};
			end else if (avs_address_i == OFF_PRESCALE) begin
				state_next.rdata = {24'h000000, state_reg.prescale};
			end else if (avs_address_i == OFF_ALIGN) begin
				state_next.rdata = {24'h000000, state_reg.align};
			end else if (avs_address_i == OFF_CONTROL) begin
				state_next.rdata = {24'h000000, state_reg.control};
			end else if (avs_address_i == OFF_SCALE_A) begin
				state_next.rdata = {24'h000000, state_reg.scale_a_value};
			end else if (avs_address_i == OFF_SCALE_B) begin
				state_next.rdata = {24'h000000, state_reg.scale_b_value};
			end
		end
		if (wr_lane0) begin
			if (avs_address_i == OFF_CLK_SEL) begin
				state_next.clk_sel = avs_writedata_i[7:0] & CLK_SEL_MASK;
			end else if (avs_address_i == OFF_PRESCALE) begin
				state_next.prescale = avs_writedata_i[7:0] & PRESCALE_MASK;
			end else if (avs_address_i == OFF_ALIGN) begin
				state_next.align = avs_writedata_i[7:0] & ALIGN_MASK;
			end else if (avs_address_i == OFF_CONTROL) begin
				state_next.control = avs_writedata_i[7:0] & CONTROL_MASK;
			end else if (avs_address_i == OFF_SCALE_A) begin
				// A write reloads the scale counter at once.
				state_next.scale_a_value = avs_writedata_i[7:0];
				state_next.scnt_a = reload(avs_writedata_i[7:0]);
			end else if (avs_address_i == OFF_SCALE_B) begin
				state_next.scale_b_value = avs_writedata_i[7:0];
				state_next.scnt_b = reload(avs_writedata_i[7:0]);
			end
		end
		// Channel clock mux; the select is live, so a change may cut one pulse short.
		for (int i = 0; i < NUM_CHAN; i++) begin
			if (CHAN_USES_B[i]) begin
				state_next.chan_en[i] = state_reg.clk_sel[i] ? state_next.scaled_b_en
					: pre_b_en;
			end else begin
				state_next.chan_en[i] = state_reg.clk_sel[i] ? state_next.scaled_a_en
					: pre_a_en;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state_reg <= '0;
			state_reg.scnt_a <= SCALE_ZERO_FULL;
			state_reg.scnt_b <= SCALE_ZERO_FULL;
		end else begin
			state_reg <= state_next;
		end
	end

	// Alignment changes are not guarded; the channel is expected to be stopped first.
	always_comb begin
		avs_waitrequest_o = (avs_read_i || avs_write_i) && !state_reg.ack;
		avs_readdata_o = state_reg.rdata;
		chan_clk_en_o = state_reg.chan_en;
		pair_join_o = {state_reg.control[JOIN_HI_BIT], state_reg.control[JOIN_MID_BIT],
			state_reg.control[JOIN_LO_BIT]};
		center_align_en_o = state_reg.align[NUM_CHAN-1:0];
		chan_out_active_o = '1;
		// The odd channel's settings govern a joined pair; the even pin goes idle.
		for (int p = 0; p < NUM_CHAN / 2; p++) begin
			if (pair_join_o[p]) begin
				chan_clk_en_o[2*p] = state_reg.chan_en[2*p+1];
				center_align_en_o[2*p] = state_reg.align[2*p+1];
				chan_out_active_o[2*p] = 1'b0;
			end
		end
		clock_a_en_o = pre_a_en;
		clock_b_en_o = pre_b_en;
		scaled_a_clk_o = state_reg.scaled_a_clk;
		scaled_b_clk_o = state_reg.scaled_b_clk;
	end
endmodule : pcc_clock_align_cfg

/* File: pcc_cfg_properties.sv */
// Checker for the clock, alignment and pair joining configuration block.
// Assumes every write enables byte lane 0, as the bench does.
`timescale 1ns/1ps
module pcc_cfg_chk
	import pcc_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic avs_waitrequest_o,
	input wire logic [5:0] center_align_en_o,
	input wire logic [5:0] chan_out_active_o,
	input wire logic [2:0] pair_join_o,
	input wire logic clock_a_en_o,
	input wire logic clock_b_en_o
);
	logic [7:0] pr_reg, al_reg, ct_reg;
	logic [7:0] d;
	assign d = avs_writedata_i[7:0];
	// A shadow copy lets the outputs be judged against what software wrote.
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			{pr_reg, al_reg, ct_reg} <= 24'h00_0000;
		end else if (avs_write_i && !avs_waitrequest_o) begin
			if (avs_address_i == OFF_PRESCALE) pr_reg <= d & PRESCALE_MASK;
			if (avs_address_i == OFF_ALIGN) al_reg <= d & ALIGN_MASK;
			if (avs_address_i == OFF_CONTROL) ct_reg <= d & CONTROL_MASK;
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	property p_nostall; avs_write_i && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
	a_nostall: assert property (p_nostall) else $error("write stalled");
	property p_a0; pr_reg[2:0] == 3'h0 |-> clock_a_en_o; endproperty
	a_a0: assert property (p_a0) else $error("clock A not undivided");
	property p_b1; (clock_b_en_o && pr_reg[6:4] == 3'h1) ##1 pr_reg[6:4] == 3'h1 |-> !clock_b_en_o; endproperty
	a_b1: assert property (p_b1) else $error("clock B not halved");
	property p_ab; pr_reg[2:0] == pr_reg[6:4] |-> clock_a_en_o == clock_b_en_o; endproperty
	a_ab: assert property (p_ab) else $error("clocks A and B apart");
	property p_join; pair_join_o == ct_reg[6:4]; endproperty
	a_join: assert property (p_join) else $error("join bits wrong");
	property p_pin; chan_out_active_o == {1'b1, !ct_reg[6], 1'b1, !ct_reg[5], 1'b1, !ct_reg[4]}; endproperty
	a_pin: assert property (p_pin) else $error("pin activity wrong");
	property p_cae; center_align_en_o == {al_reg[5], ct_reg[6] ? al_reg[5] : al_reg[4], al_reg[3],
		ct_reg[5] ? al_reg[3] : al_reg[2], al_reg[1], ct_reg[4] ? al_reg[1] : al_reg[0]}; endproperty
	a_cae: assert property (p_cae) else $error("alignment wrong");
	property p_rst; $fell(reset_i) |-> pair_join_o == 3'h0 && center_align_en_o == 6'h00; endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule : pcc_cfg_chk
bind pcc_clock_align_cfg pcc_cfg_chk chk_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
	.avs_address_i(avs_address_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_waitrequest_o(avs_waitrequest_o), .center_align_en_o(center_align_en_o),
	.chan_out_active_o(chan_out_active_o), .pair_join_o(pair_join_o),
	.clock_a_en_o(clock_a_en_o), .clock_b_en_o(clock_b_en_o));

/* File: tb.sv */
// Self-checking bench for the configuration block.
// Assumes one wait cycle per request; byte lanes stay enabled.
`timescale 1ns/1ps
module tb;
	import pcc_pkg::*;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0000_0000;
	logic [31:0] rdata, q;
	logic wt, ca, cb, sa, sb;
	logic [5:0] ce, cae, act;
	logic [2:0] pj;
	int fails = 0;
	int checks = 0;
	int n[6];
	logic [7:0] offs[4] = '{OFF_CLK_SEL, OFF_PRESCALE, OFF_ALIGN, OFF_CONTROL};
	logic [7:0] msk[4] = '{CLK_SEL_MASK, PRESCALE_MASK, ALIGN_MASK, CONTROL_MASK};
	pcc_clock_align_cfg dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wt), .chan_clk_en_o(ce),
		.center_align_en_o(cae), .chan_out_active_o(act), .pair_join_o(pj),
		.clock_a_en_o(ca), .clock_b_en_o(cb), .scaled_a_clk_o(sa), .scaled_b_clk_o(sb));
	initial forever #4 sys_clk_i = ~sys_clk_i;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
		int k;
		k = 0;
		@(posedge sys_clk_i);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= {24'h00_0000, v};
		do @(negedge sys_clk_i); while (wt !== 1'b0 && ++k < 20);
		q = rdata;
		@(posedge sys_clk_i);
		wr <= 1'b0;
		rd <= 1'b0;
		if (k == 20) chk("waitrequest", 32'h0, 32'h1);
		#1;
	endtask : bus
	// Two settle cycles keep the delayed channel enables out of a stale window.
	task automatic cnt();
		logic pa, pb;
		repeat (2) @(negedge sys_clk_i);
		n = '{default: 0};
		pa = sa;
		pb = sb;
		repeat (256) begin
			@(negedge sys_clk_i);
			n[0] += ca;
			n[1] += cb;
			n[2] += ce[0];
			n[3] += ce[2];
			n[4] += sa & !pa;
			n[5] += sb & !pb;
			pa = sa;
			pb = sb;
		end
	endtask : cnt
	task automatic t_reset();
		foreach (offs[i]) begin
			bus(1'b0, offs[i], 8'h00);
			chk("reset value", 32'h0, q);
		end
		chk("pins", 32'h3f, {26'h0, act});
		$display("test reset done");
	endtask : t_reset
	task automatic t_regs();
		foreach (offs[i]) begin
			bus(1'b1, offs[i], 8'hff);
			bus(1'b0, offs[i], 8'h00);
			chk("readback", {24'h0, msk[i]}, q);
		end
		chk("join", 32'h7, {29'h0, pj});
		chk("pins", 32'h2a, {26'h0, act});
		bus(1'b1, OFF_ALIGN, 8'h15);
		chk("align joined", 32'h0, {26'h0, cae});
		bus(1'b1, OFF_CONTROL, 8'h00);
		chk("align", 32'h15, {26'h0, cae});
		bus(1'b1, 8'h18, 8'hff);
		bus(1'b0, 8'h18, 8'h00);
		chk("unmapped", 32'h0, q);
		foreach (offs[i]) bus(1'b1, offs[i], 8'h00);
		$display("test registers done");
	endtask : t_regs
	task automatic t_pre();
		for (int s = 0; s < 8; s++) begin
			bus(1'b1, OFF_PRESCALE, 8'(s) | (8'(7 - s) << PRE_B_LSB));
			cnt();
			chk("clock A", 256 >> s, n[0]);
			chk("clock B", 256 >> (7 - s), n[1]);
			chk("chan 0", 256 >> s, n[2]);
			chk("chan 2", 256 >> (7 - s), n[3]);
		end
		$display("test prescale done");
	endtask : t_pre
	task automatic t_scale();
		bus(1'b1, OFF_PRESCALE, 8'h00);
		bus(1'b1, OFF_SCALE_A, 8'h02);
		bus(1'b1, OFF_SCALE_B, 8'h01);
		cnt();
		chk("scaled A", 32'd64, n[4]);
		chk("scaled B", 32'd128, n[5]);
		bus(1'b1, OFF_CLK_SEL, 8'h3f);
		cnt();
		chk("chan 0 scaled", 32'd64, n[2]);
		chk("chan 2 scaled", 32'd128, n[3]);
		$display("test scale done");
	endtask : t_scale
	task automatic end_sim();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_sim
	initial begin
		repeat (5) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_regs();
		t_pre();
		t_scale();
		end_sim();
	end
	initial begin
		#200000;
		fails++;
		end_sim();
	end
endmodule : tb
